/* File: nvm_prog_defs.vh */
`ifndef NVM_PROG_DEFS_VH
`define NVM_PROG_DEFS_VH
`define PAGE_TEST        3'h0
`define PAGE_RAM         3'h1
`define PAGE_FUNC        3'h2
`define PAGE_CACHE       3'h5
`define REG_BANK_CTRL    8'h0D
`define REG_TAKEOVER     8'h0E
`define TAKEOVER_CODE    8'h03
`define PROG_BIT         3
`define BANK_MAX         3'h5
`define BANK5            3'h5
`define CRC_BYTE_IDX     4'h8
`define CRC_INIT         8'hFF
`define BANK5_LAST_CRC   4'h7
`define BANK5_COMMIT     4'h8
`define CACHE_LOAD_NS    8000
`define PROGRAM_NS       15000000
`define CLK_NS           20
`define STAT_CRC_ERR     6
`define STAT_GOOD        5
`define STAT_PROG_BUSY   1
`define STAT_LOAD_BUSY   0
`endif

/* File: nvm_prog_ctrl.v */
`timescale 1ns/10ps
`default_nettype none
`include "nvm_prog_defs.vh"

module nvm_prog_ctrl #(
  parameter integer LOAD_CYC = `CACHE_LOAD_NS / `CLK_NS,
  parameter integer PROG_CYC = `PROGRAM_NS / `CLK_NS
) (
  input  wire         clk,
  input  wire         srst,
  // host access, 11-bit address: page in [10:8]
  input  wire         host_wr,
  input  wire         host_rd,
  input  wire [10:0]  host_addr,
  input  wire [7:0]   host_wdata,
  output reg  [7:0]   host_rdata,
  output reg          host_rvalid,
  // page selects toward the other memories
  output reg          ram_sel,
  output reg          func_sel,
  output reg          test_sel,
  output reg  [7:0]   fwd_addr,
  output reg  [7:0]   fwd_wdata,
  output reg          fwd_wr,
  output reg          fwd_rd,
  // processor hold and routing
  output reg          cpu_hold,
  output reg          if_route,
  // cell array
  output reg          cell_wr,
  output reg  [2:0]   cell_bank,
  output reg  [127:0] cell_wdata,
  output reg  [127:0] cell_wmask,
  input  wire [127:0] cell_rdata,
  // status
  output reg  [7:0]   nvm_status_register,
  output reg          cache_load_busy,
  output reg          program_busy,
  output reg          program_ok_flag
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_LOAD = 3'b010;
  localparam [2:0] ST_PROG = 3'b100;

  reg [2:0]   state_q;
  reg [19:0]  timer_q;
  reg [2:0]   bank_q;
  reg [7:0]   cache_q [0:15];
  reg [7:0]   bank_crc_q [1:4];
  reg         crc_err_q;
  reg         good_q;
  reg [7:0]   crc_v;
  reg [7:0]   calc;
  reg [127:0] flat;
  reg [3:0]   lim;
  integer     i;
  integer     b;

  wire [2:0]  page = host_addr[10:8];
  wire [7:0]  low  = host_addr[7:0];
  // test page only from the interface
  wire        test_hit = page == `PAGE_TEST;
  wire        wr_ctrl  = host_wr && test_hit && low == `REG_BANK_CTRL;
  // bank field, out of range ignored
  wire        bank_ok  = host_wdata[2:0] <= `BANK_MAX;

  // one byte step of the crc
  function [7:0] crc_step;
    input [7:0] c;
    input [7:0] d;
    begin
      crc_step[0] = d[7]^d[6]^d[0]^c[0]^c[6]^c[7];
      crc_step[1] = d[6]^d[1]^d[0]^c[0]^c[1]^c[6];
      // next crc depends on c^d only, so c terms mirror the d terms
      crc_step[2] = d[6]^d[2]^d[1]^d[0]^c[0]^c[1]^c[2]^c[6];
      crc_step[3] = d[7]^d[3]^d[2]^d[1]^c[1]^c[2]^c[3]^c[7];
      crc_step[4] = d[4]^d[3]^d[2]^c[2]^c[3]^c[4];
      crc_step[5] = d[5]^d[4]^d[3]^c[3]^c[4]^c[5];
      crc_step[6] = d[6]^d[5]^d[4]^c[4]^c[5]^c[6];
      crc_step[7] = d[7]^d[6]^d[5]^c[5]^c[6]^c[7];
    end
  endfunction

  // ----------------------------------------
  // crc of the cache contents
  // ----------------------------------------
  always @* begin
    // start from stored banks, then the bytes of the current bank (bytes 0 to 7 for bank 5)
    crc_v = `CRC_INIT;
    calc  = `CRC_INIT;
    lim   = (bank_q == `BANK5) ? `BANK5_LAST_CRC : 4'hF;
    // bank n of 2 to 5 continues the chain left by bank n-1; banks 0 and 1 start from CRC_INIT
    for (b = 1; b <= 4; b = b + 1) begin
      if (bank_q == b[2:0] + 3'h1)
        crc_v = bank_crc_q[b];
    end
    for (i = 0; i < 16; i = i + 1) begin
      if (i[3:0] <= lim)
        crc_v = crc_step(crc_v, cache_q[i]);
    end
    calc = crc_v;
    for (i = 0; i < 16; i = i + 1) begin
      flat[i*8 +: 8] = cache_q[i];
    end
  end

  // ----------------------------------------
  // control
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      state_q   <= ST_IDLE;
      timer_q   <= 20'h0_0000;
      bank_q    <= 3'h0;
      crc_err_q <= 1'b0;
      good_q    <= 1'b0;
      cpu_hold  <= 1'b0;
      if_route  <= 1'b0;
      cell_wr   <= 1'b0;
      cell_bank <= 3'h0;
      cell_wdata <= 128'h0;
      cell_wmask <= 128'h0;
      for (i = 0; i < 16; i = i + 1)
        cache_q[i] <= 8'h00;
      for (i = 1; i <= 4; i = i + 1)
        bank_crc_q[i] <= `CRC_INIT;
    end else begin
      cell_wr <= 1'b0;
      if (host_wr && test_hit && low == `REG_TAKEOVER) begin
        cpu_hold <= host_wdata == `TAKEOVER_CODE;
        if_route <= host_wdata == `TAKEOVER_CODE;
      end
      case (state_q)
        ST_IDLE: begin
          if (host_wr && page == `PAGE_CACHE)
            cache_q[low[3:0]] <= host_wdata;
          if (wr_ctrl && bank_ok) begin
            bank_q <= host_wdata[2:0];
            // cells must show the new bank before the load ends
            cell_bank <= host_wdata[2:0];
            if (host_wdata[`PROG_BIT]) begin
              state_q <= ST_PROG;
              timer_q <= PROG_CYC[19:0];
            end else begin
              state_q <= ST_LOAD;
              timer_q <= LOAD_CYC[19:0];
            end
          end
        end
        ST_LOAD: begin
          if (timer_q == 20'h0_0001) begin
            state_q <= ST_IDLE;
            for (i = 0; i < 16; i = i + 1)
              cache_q[i] <= cell_rdata[i*8 +: 8];
          end
          timer_q <= timer_q - 20'h0_0001;
        end
        ST_PROG: begin
          if (timer_q == 20'h0_0001) begin
            state_q    <= ST_IDLE;
            cell_wr    <= 1'b1;
            cell_bank  <= bank_q;
            cell_wdata <= flat;
            cell_wmask <= (bank_q == `BANK5) ?
                          {56'h0, {72{1'b1}}} : {128{1'b1}};
            if (bank_q == 3'h0) begin
              crc_err_q <= 1'b0;
              good_q    <= 1'b1;
            end else if (bank_q == `BANK5) begin
              crc_err_q <= cache_q[`CRC_BYTE_IDX] != calc;
              good_q    <= cache_q[`CRC_BYTE_IDX] == calc;
            end else begin
              bank_crc_q[bank_q] <= calc;
              crc_err_q <= 1'b0;
              good_q    <= 1'b1;
            end
          end
          timer_q <= timer_q - 20'h0_0001;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // page decode and status
  // ----------------------------------------
  always @(posedge clk) begin
    if (srst) begin
      host_rdata  <= 8'h00;
      host_rvalid <= 1'b0;
      ram_sel     <= 1'b0;
      func_sel    <= 1'b0;
      test_sel    <= 1'b0;
      fwd_addr    <= 8'h00;
      fwd_wdata   <= 8'h00;
      fwd_wr      <= 1'b0;
      fwd_rd      <= 1'b0;
      nvm_status_register <= 8'h00;
      cache_load_busy <= 1'b0;
      program_busy    <= 1'b0;
      program_ok_flag <= 1'b0;
    end else begin
      // ram page, function page, test page
      ram_sel   <= page == `PAGE_RAM;
      func_sel  <= page == `PAGE_FUNC;
      test_sel  <= test_hit;
      fwd_addr  <= low;
      fwd_wdata <= host_wdata;
      fwd_wr    <= host_wr && page != `PAGE_CACHE;
      fwd_rd    <= host_rd && page != `PAGE_CACHE;
      host_rvalid <= host_rd && page == `PAGE_CACHE;
      host_rdata  <= cache_q[low[3:0]];
      cache_load_busy <= state_q == ST_LOAD ||
                         (state_q == ST_IDLE && wr_ctrl && bank_ok &&
                          !host_wdata[`PROG_BIT]);
      program_busy    <= state_q == ST_PROG ||
                         (state_q == ST_IDLE && wr_ctrl && bank_ok &&
                          host_wdata[`PROG_BIT]);
      program_ok_flag <= good_q;
      nvm_status_register <= 8'h00;
      nvm_status_register[`STAT_CRC_ERR]   <= crc_err_q;
      nvm_status_register[`STAT_GOOD]      <= good_q;
      nvm_status_register[`STAT_PROG_BUSY] <= state_q == ST_PROG;
      nvm_status_register[`STAT_LOAD_BUSY] <= state_q == ST_LOAD;
    end
  end

endmodule // nvm_prog_ctrl
`default_nettype wire

/* File: nvm_cells_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nvm_cells_model (
  // cell array side
  input  wire logic         clk,
  input  wire logic         cell_wr,
  input  wire logic [2:0]   cell_bank,
  input  wire logic [127:0] cell_wdata,
  input  wire logic [127:0] cell_wmask,
  output logic      [127:0] cell_rdata
);
  logic [127:0] mem [0:7];
  // byte pattern carries both bank and byte index
  initial begin
    for (int b = 0; b < 8; b++)
      for (int i = 0; i < 16; i++)
        mem[b][8*i+:8] = {i[3:0], 1'b0, b[2:0]};
  end
  always @(posedge clk) begin
    if (cell_wr) begin
      mem[cell_bank] <= (mem[cell_bank] & ~cell_wmask) |
                        (cell_wdata & cell_wmask);
    end
  end
  assign cell_rdata = mem[cell_bank];
endmodule // nvm_cells_model
`default_nettype wire

/* File: nvm_prog_ctrl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module nvm_prog_ctrl_chk (
  // watched ports
  input wire logic         clk,
  input wire logic         srst,
  input wire logic         host_wr,
  input wire logic [10:0]  host_addr,
  input wire logic [7:0]   host_wdata,
  input wire logic         ram_sel,
  input wire logic         func_sel,
  input wire logic         test_sel,
  input wire logic         cpu_hold,
  input wire logic         if_route,
  input wire logic         cell_wr,
  input wire logic [2:0]   cell_bank,
  input wire logic [127:0] cell_wmask,
  input wire logic [7:0]   nvm_status_register,
  input wire logic         cache_load_busy,
  input wire logic         program_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  wire idle = !cache_load_busy && !program_busy;
  wire ctl_wr = host_wr && host_addr == 11'h00d && idle;
  wire ok_bank = host_wdata[2:0] <= 3'h5;
  // past check keeps a reset release from looking like an end
  sequence s_prog_end;
    $fell(program_busy) && !$past(srst);
  endsequence
  chk_takeover_route: assert property (host_wr && host_addr == 11'h00e &&
    host_wdata == 8'h03 |=> cpu_hold && if_route) else $error("no takeover");
  chk_load_start: assert property (ctl_wr && !host_wdata[3] && ok_bank
    |=> cache_load_busy) else $error("load not started");
  chk_prog_start: assert property (ctl_wr && host_wdata[3] && ok_bank
    |=> program_busy) else $error("program not started");
  chk_bad_bank: assert property (ctl_wr && !ok_bank
    |=> idle) else $error("bank 6 or 7 accepted");
  chk_ram_page: assert property (host_wr && host_addr[10:8] == 3'h1
    |=> ram_sel) else $error("ram page not decoded");
  chk_func_page: assert property (host_wr && host_addr[10:8] == 3'h2
    |=> func_sel) else $error("function page not decoded");
  chk_test_page: assert property (host_wr && host_addr[10:8] == 3'h0
    |=> test_sel) else $error("test page not decoded");
  chk_bank0_good: assert property (s_prog_end ##0 cell_bank == 3'h0
    |-> ##[0:2] nvm_status_register[6:5] == 2'b01) else $error("bank 0 bad");
  chk_bank5_mask: assert property (cell_wr && cell_bank == 3'h5
    |-> cell_wmask == {56'h0, {72{1'b1}}}) else $error("bank 5 mask");
  chk_prog_commit: assert property (s_prog_end
    |-> $past(cell_wr)) else $error("program ended without write");
endmodule // nvm_prog_ctrl_chk
bind nvm_prog_ctrl nvm_prog_ctrl_chk i_nvm_prog_ctrl_chk (.clk(clk),
  .srst(srst), .host_wr(host_wr), .host_addr(host_addr),
  .host_wdata(host_wdata), .ram_sel(ram_sel), .func_sel(func_sel),
  .test_sel(test_sel), .cpu_hold(cpu_hold), .if_route(if_route),
  .cell_wr(cell_wr), .cell_bank(cell_bank), .cell_wmask(cell_wmask),
  .nvm_status_register(nvm_status_register),
  .cache_load_busy(cache_load_busy), .program_busy(program_busy));
`default_nettype wire

/* File: tb_nvm_prog_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_nvm_prog_ctrl;
  logic clk = 0, srst = 1, host_wr = 0, host_rd = 0, host_rvalid, ram_sel;
  logic func_sel, test_sel, cpu_hold, if_route, cell_wr, program_ok_flag;
  logic cache_load_busy, program_busy;
  logic [10:0] host_addr = '0;
  logic [7:0] host_wdata = '0, host_rdata, nvm_status_register;
  logic [7:0] crc_q = 8'hff;
  logic [2:0] cell_bank;
  logic [127:0] cell_wdata, cell_wmask, cell_rdata;
  int fail_count = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  nvm_prog_ctrl #(.LOAD_CYC(20), .PROG_CYC(50)) i_nvm_prog_ctrl (.clk(clk),
    .srst(srst), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .ram_sel(ram_sel), .func_sel(func_sel),
    .test_sel(test_sel), .fwd_addr(), .fwd_wdata(), .fwd_wr(), .fwd_rd(),
    .cpu_hold(cpu_hold), .if_route(if_route), .cell_wr(cell_wr),
    .cell_bank(cell_bank), .cell_wdata(cell_wdata), .cell_wmask(cell_wmask),
    .cell_rdata(cell_rdata), .nvm_status_register(nvm_status_register),
    .cache_load_busy(cache_load_busy), .program_busy(program_busy),
    .program_ok_flag(program_ok_flag));
  nvm_cells_model i_nvm_cells_model (.clk(clk), .cell_wr(cell_wr),
    .cell_bank(cell_bank), .cell_wdata(cell_wdata),
    .cell_wmask(cell_wmask), .cell_rdata(cell_rdata));
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    host_wr = 1;
    host_addr = a;
    host_wdata = d;
    @(posedge clk) #1;
    host_wr = 0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && (cache_load_busy | program_busy) !== 1'b0; i++)
      @(posedge clk) #1;
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int k = 0; k < 8; k++)
      x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
    return x;
  endfunction
  // load, read back, fill, program, judge status
  task automatic prog(input logic [2:0] b, input logic bad);
    logic [7:0] d, c;
    c = crc_q;
    wr(11'h00d, {5'h00, b});
    wait_idle();
    host_rd = 1;
    host_addr = 11'h5f3;
    @(posedge clk) #1;
    host_rd = 0;
    for (int i = 0; i < 4 && host_rvalid !== 1'b1; i++) @(posedge clk) #1;
    chk(host_rdata, bad ? {b, 1'b1, 4'h3} : {4'h3, 1'b0, b});
    for (int i = 0; i < 16; i++) begin
      d = {b, 1'b1, i[3:0]};
      if (b == 3'h5 && i == 8) d = c ^ {7'h00, bad};
      else if (b != 3'h0 && (b != 3'h5 || i < 8)) c = crc8(c, d);
      wr({7'h5a, i[3:0]}, d);
    end
    if (b != 3'h0 && b != 3'h5) crc_q = c;
    wr(11'h00d, {5'h01, b});
    wait_idle();
    repeat (2) @(posedge clk) #1;
    chk({6'h00, nvm_status_register[6:5]}, {6'h00, bad, !bad});
    chk({7'h00, program_ok_flag}, {7'h00, !bad});
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 srst = 0;
    wr(11'h00e, 8'h03);
    chk({5'h00, test_sel, cpu_hold, if_route}, 8'h07);
    wr(11'h1a5, 8'h5c);
    chk({6'h00, ram_sel, func_sel}, 8'h02);
    wr(11'h2c3, 8'h11);
    chk({6'h00, ram_sel, func_sel}, 8'h01);
    wr(11'h00d, 8'h06);
    chk({6'h00, cache_load_busy, program_busy}, 8'h00);
    prog(3'h0, 1'b0);
    // banks 1 to 4 before bank 5
    for (int b = 1; b < 5; b++) prog(b[2:0], 1'b0);
    prog(3'h5, 1'b0);
    chk(i_nvm_cells_model.mem[1][127:120], 8'h3f);
    chk(i_nvm_cells_model.mem[5][127:120], 8'hf5);
    prog(3'h5, 1'b1);
    summarize();
  end
endmodule // tb_nvm_prog_ctrl
`default_nettype wire
